/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic link_ok = 1'b0, an_enable = 1'b1, an_duplex = 1'b0, an_speed10 = 1'b0;
  logic enhanced_mode = 1'b1, strap_duplex = 1'b0, strap_speed10 = 1'b1;
  logic ieee_pwrdn = 1'b0, energy_det = 1'b0, col_raw = 1'b0, pin_in = 1'b1;
  logic [7:0] flag_events = 8'h00;
  logic pin_out, pin_oe, pwrdn_req, clk_off, sleep_active, nlp_pulse, scr_bypass;
  logic col_out, irq;
  logic [3:0] fifo_depth;
  logic [15:0] d;
  int fail_count = 0;
  int cmp_count = 0;
  int i;
  // A short link pulse period keeps the sleep scenario brief.
  pscr_regs #(.NLP_PERIOD(20)) uut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .link_ok(link_ok), .an_enable(an_enable),
    .an_duplex(an_duplex), .an_speed10(an_speed10), .enhanced_mode(enhanced_mode),
    .strap_duplex(strap_duplex), .strap_speed10(strap_speed10), .ieee_pwrdn(ieee_pwrdn),
    .energy_det(energy_det), .flag_events(flag_events), .col_raw(col_raw),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pwrdn_req(pwrdn_req),
    .clk_off(clk_off), .sleep_active(sleep_active), .nlp_pulse(nlp_pulse),
    .scr_bypass(scr_bypass), .fifo_depth(fifo_depth), .col_out(col_out), .irq(irq));
  always #12.5 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    cyc(3);
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_reset;
    rd_reg(pscr_pkg::OFS_CTRL, d);
    chk("ctrl reset", 16'h0108, d);
    chk("fifo reset", 16'h0005, {12'h000, fifo_depth});
    chk("pin reset", 16'h0002, {14'h0000, pin_out, pin_oe});
    rd_reg(5'h1F, d);
    chk("unmapped", 16'h0000, d);
  endtask
  task automatic t_ctrl;
    logic [3:0] dep [4];
    dep = '{4'h4, 4'h5, 4'h6, 4'h8};
    wr_reg(pscr_pkg::OFS_CTRL, 16'h0FFA);
    rd_reg(pscr_pkg::OFS_CTRL, d);
    chk("ctrl rsvd", 16'h0F1A, d);
    chk("scr byp", 16'h0001, {15'h0000, scr_bypass});
    for (i = 0; i < 4; i++)
    begin
      wr_reg(pscr_pkg::OFS_CTRL, {6'h00, i[1:0], 8'h08});
      chk("fifo depth", {12'h000, dep[i]}, {12'h000, fifo_depth});
    end
  endtask
  task automatic t_status;
    @(posedge clk);
    an_enable <= 1'b0;
    link_ok <= 1'b1;
    cyc(4);
    rd_reg(pscr_pkg::OFS_STATUS, d);
    chk("sts enh", 16'h0007, {13'h0000, d[2:0]});
    rd_reg(pscr_pkg::OFS_STATUS, d);
    chk("sts link", 16'h0001, {15'h0000, d[0]});
    // Straps are latched only at reset release, so a second reset is needed.
    @(posedge clk);
    nrst <= 1'b0;
    enhanced_mode <= 1'b0;
    strap_duplex <= 1'b1;
    strap_speed10 <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    strap_duplex <= 1'b0;
    strap_speed10 <= 1'b1;
    cyc(4);
    rd_reg(pscr_pkg::OFS_STATUS, d);
    chk("sts strap", 16'h0005, {13'h0000, d[2:0]});
    @(posedge clk);
    an_enable <= 1'b1;
    an_duplex <= 1'b1;
  endtask
  task automatic t_irq;
    wr_reg(pscr_pkg::OFS_EVENTS, 16'h0020);
    wr_reg(pscr_pkg::OFS_CTRL, 16'h0101);
    chk("pin oe", 16'h0001, {15'h0000, pin_oe});
    @(posedge clk);
    flag_events <= 8'h20;
    @(posedge clk);
    flag_events <= 8'h00;
    cyc(3);
    chk("no global en", 16'h0000, {15'h0000, pin_out});
    wr_reg(pscr_pkg::OFS_CTRL, 16'h0103);
    chk("event irq", 16'h0001, {15'h0000, pin_out});
    rd_reg(pscr_pkg::OFS_EVENTS, d);
    chk("events rd", 16'h2020, d);
    cyc(3);
    chk("flag cleared", 16'h0000, {15'h0000, pin_out});
    wr_reg(pscr_pkg::OFS_CTRL, 16'h0107);
    chk("test irq", 16'h0001, {15'h0000, pin_out});
    wr_reg(pscr_pkg::OFS_CTRL, 16'h010F);
    chk("test low pol", 16'h0000, {15'h0000, pin_out});
    wr_reg(pscr_pkg::OFS_CTRL, 16'h0108);
    @(posedge clk);
    pin_in <= 1'b0;
    cyc(5);
    chk("pwrdn pin", 16'h0001, {15'h0000, pwrdn_req});
    @(posedge clk);
    pin_in <= 1'b1;
  endtask
  task automatic t_blk_irq;
    wr_reg(pscr_pkg::OFS_IRQ_MASK, 16'h0002);
    rd_reg(pscr_pkg::OFS_IRQ_STAT, d);
    cyc(2);
    chk("blk quiet", 16'h0000, {15'h0000, irq});
    @(posedge clk);
    link_ok <= 1'b0;
    cyc(4);
    chk("blk irq", 16'h0001, {15'h0000, irq});
    rd_reg(pscr_pkg::OFS_IRQ_STAT, d);
    chk("blk stat", 16'h0002, d & 16'h0002);
    cyc(3);
    chk("blk clr", 16'h0000, {15'h0000, irq});
  endtask
  task automatic t_misc;
    @(posedge clk);
    col_raw <= 1'b1;
    cyc(3);
    chk("col fd off", 16'h0000, {15'h0000, col_out});
    wr_reg(pscr_pkg::OFS_CTRL, 16'h8118);
    chk("col fd on", 16'h0001, {15'h0000, col_out});
    chk("clk kept", 16'h0000, {15'h0000, clk_off});
    @(posedge clk);
    ieee_pwrdn <= 1'b1;
    cyc(3);
    chk("clk off", 16'h0001, {15'h0000, clk_off});
    @(posedge clk);
    ieee_pwrdn <= 1'b0;
    wr_reg(pscr_pkg::OFS_CTRL, 16'h5108);
    chk("ps mode 1", 16'h0000, {15'h0000, sleep_active});
    wr_reg(pscr_pkg::OFS_CTRL, 16'h2108);
    chk("ps gated", 16'h0000, {15'h0000, sleep_active});
    wr_reg(pscr_pkg::OFS_CTRL, 16'h6108);
    chk("sleep", 16'h0001, {15'h0000, sleep_active});
    d = 16'h0000;
    for (i = 0; i < 45; i++)
    begin
      cyc(1);
      d = d + {15'h0000, nlp_pulse};
    end
    chk("nlp count", 16'h0002, d);
    @(posedge clk);
    energy_det <= 1'b1;
    cyc(8);
    chk("wake", 16'h0000, {15'h0000, sleep_active});
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_ctrl();
    t_status();
    t_irq();
    t_blk_irq();
    t_misc();
    end_of_test();
  end
  initial
  begin
    #(25 * 4000);
    fail_count++;
    end_of_test();
  end
endmodule // testbench

/* rtl/pscr_pkg.sv */
package pscr_pkg;

  // Register indices on the management port; the byte address is the index itself.
  localparam logic [4:0] OFS_BMS = 5'h01;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  localparam logic [4:0] OFS_CTRL = 5'h11;
  localparam logic [4:0] OFS_EVENTS = 5'h12;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h18;
  localparam logic [4:0] OFS_IRQ_MASK = 5'h19;

  localparam logic [15:0] CTRL_RESET = 16'h0108;
  localparam logic [15:0] CTRL_WR_MASK = 16'hFF1F;
  localparam logic [15:0] EVENTS_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0002;

  localparam int CTRL_CLK_OFF = 15;
  localparam int CTRL_PS_EN = 14;
  localparam int CTRL_PS_HI = 13;
  localparam int CTRL_PS_LO = 12;
  localparam int CTRL_SCR_BYP = 11;
  localparam int CTRL_FIFO_HI = 9;
  localparam int CTRL_FIFO_LO = 8;
  localparam int CTRL_COL_FD = 4;
  localparam int CTRL_IRQ_POL = 3;
  localparam int CTRL_IRQ_TEST = 2;
  localparam int CTRL_IRQ_EN = 1;
  localparam int CTRL_PIN_IRQ = 0;

  localparam int STS_DUPLEX = 2;
  localparam int STS_SPEED = 1;
  localparam int STS_LINK = 0;

  localparam logic [1:0] PS_NORMAL = 2'h0;
  localparam logic [1:0] PS_ACTIVE_SLEEP = 2'h2;

  localparam int FLAG_LINK = 13;
  localparam int FLAG_SPEED = 12;
  localparam int FLAG_DUPLEX = 11;

  // Local block interrupt bits.
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_LINK = 1;

  localparam int CLK_HZ = 40_000_000;
  localparam int NLP_PERIOD_MS = 1400;
  localparam int NLP_PERIOD_CYC = (CLK_HZ / 1000) * NLP_PERIOD_MS;

endpackage

/* rtl/pscr_regs.sv */
`timescale 1ns/1ps
// Operation
// - Status bit 2 is duplex; with negotiation off, strap or fixed 1 by mode.
// - Status bit 1 is speed, 1 means 10 Mbps, resets 1; same off rules.
// - Status bit 0 mirrors common_pinout_mode status link bit; reading status never clears it.
// - Control bit 15 shuts clocks, honoured only in IEEE power down.
// - Control bit 14 gates power save; at 1 the bits 13-12 mode applies.
// - Power save field: 0 normal, 1 reserved, 2 active sleep.
// - Active sleep keeps management and energy detect; link pulse every 1.4 s.
// - Control bit 11 bypasses the scrambler when set.
// - Loopback depth bits 9-8 give 4, 5, 6, 8 nibbles; reset code 1.
// - Loopback FIFO absorbs rx/tx rate difference; software picks depth.
// - Bit 4 zero: collision only half duplex; one: also in full duplex.
// - Bit 3 sets interrupt polarity; reset 1 means idle high, active low.
// - Bit 2 forces interrupts continuously while set.
// - Bit 1 globally enables event interrupts gated by individual enables.
// - Bit 0 selects shared pin: power down input or interrupt, polarity set by bit 3.
// - Control bits 7-5 are reserved, read-only zero.
// - Event register upper byte clear-on-read flags, lower byte enables.
module pscr_regs #(
  parameter int NLP_PERIOD = pscr_pkg::NLP_PERIOD_CYC
) (
  input wire logic clk, // 40 MHz clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic [4:0] addr, // register index
  input wire logic [15:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [15:0] rdata, // read data, cycle after rd
  input wire logic link_ok, // resolved link from common_pinout_mode status
  input wire logic an_enable, // auto-negotiation enabled
  input wire logic an_duplex, // negotiated duplex, 1 full
  input wire logic an_speed10, // negotiated speed, 1 means 10 Mbps
  input wire logic enhanced_mode, // 1 extended-feature mode, 0 common pinout
  input wire logic strap_duplex, // strap for duplex
  input wire logic strap_speed10, // strap for speed
  input wire logic ieee_pwrdn, // common_pinout_mode control power down bit
  input wire logic energy_det, // energy on the line, from a pin
  input wire logic [7:0] flag_events, // event pulses for flags 15-8
  input wire logic col_raw, // raw collision detect
  input wire logic pin_in, // shared pin input level
  output logic pin_out, // shared pin output value
  output logic pin_oe, // shared pin output enable
  output logic pwrdn_req, // power down requested through the pin
  output logic clk_off, // internal clock circuitry shut off
  output logic sleep_active, // active sleep in force
  output logic nlp_pulse, // normal link pulse request, one cycle
  output logic scr_bypass, // scrambler bypass
  output logic [3:0] fifo_depth, // loopback FIFO depth in nibbles
  output logic col_out, // collision to the MAC
  output logic irq // block level interrupt
);

  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] ena_reg;
  logic [1:0] istat_reg;
  logic [1:0] istat_next;
  logic [1:0] imask_reg;
  logic duplex_reg;
  logic speed_reg;
  logic strap_dup_reg;
  logic strap_spd_reg;
  logic strap_taken_reg;
  logic [1:0] en_sync_reg;
  logic [1:0] pin_sync_reg;
  logic [31:0] nlp_cnt_reg;
  logic link_prev_reg;
  logic [15:0] rdata_reg;
  logic pin_out_reg;
  logic pin_oe_reg;
  logic pwrdn_reg;
  logic clk_off_reg;
  logic sleep_reg;
  logic nlp_reg;
  logic col_reg;
  logic irq_reg;
  logic [3:0] fifo_depth_reg;

  function automatic logic [3:0] depth_of(input logic [1:0] code);
    unique case (code)
      2'h0: depth_of = 4'h4;
      2'h1: depth_of = 4'h5;
      2'h2: depth_of = 4'h6;
      2'h3: depth_of = 4'h8;
    endcase
  endfunction

  wire sel_ctrl = addr == pscr_pkg::OFS_CTRL;
  wire sel_events = addr == pscr_pkg::OFS_EVENTS;
  wire sel_status = addr == pscr_pkg::OFS_STATUS;
  wire sel_istat = addr == pscr_pkg::OFS_IRQ_STAT;
  wire sel_imask = addr == pscr_pkg::OFS_IRQ_MASK;
  wire sel_bms = addr == pscr_pkg::OFS_BMS;

  // With negotiation off the common pinout uses the straps, the other mode fixed 1.
  wire duplex_now = an_enable ? an_duplex : (enhanced_mode ? 1'b1 : strap_dup_reg);
  wire speed_now = an_enable ? an_speed10 : (enhanced_mode ? 1'b1 : strap_spd_reg);

  wire [15:0] status_word = {13'h0000, duplex_reg, speed_reg, link_ok};
  wire [15:0] events_word = {flags_reg, ena_reg};

  wire ps_on = ctrl_reg[pscr_pkg::CTRL_PS_EN];
  wire [1:0] ps_mode = ctrl_reg[pscr_pkg::CTRL_PS_HI:pscr_pkg::CTRL_PS_LO];
  wire sleep_now = ps_on && (ps_mode == pscr_pkg::PS_ACTIVE_SLEEP);
  // Energy from a partner wakes the device by dropping the power save enable.
  wire wake = sleep_now && en_sync_reg[1];

  wire pend = |(flags_reg & ena_reg);
  wire assert_irq = (ctrl_reg[pscr_pkg::CTRL_IRQ_EN] && pend)
                    || ctrl_reg[pscr_pkg::CTRL_IRQ_TEST];
  wire pin_is_irq = ctrl_reg[pscr_pkg::CTRL_PIN_IRQ];

  wire link_chg = link_ok != link_prev_reg;
  wire [1:0] istat_set = {link_chg, wake};

  wire [15:0] rd_mux = sel_ctrl ? ctrl_reg :
                       sel_events ? events_word :
                       sel_status ? status_word :
                       sel_bms ? {13'h0000, link_ok, 2'h0} :
                       sel_istat ? {14'h0000, istat_reg} :
                       sel_imask ? {14'h0000, imask_reg} : 16'h0000;

  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (wr && sel_ctrl)
    begin
      ctrl_next = wdata & pscr_pkg::CTRL_WR_MASK;
    end
    if (wake)
    begin
      ctrl_next[pscr_pkg::CTRL_PS_EN] = 1'b0;
    end
    // Set wins over the read clear so no event is lost.
    flags_next = ((rd && sel_events) ? 8'h00 : flags_reg) | flag_events;
    istat_next = ((rd && sel_istat) ? 2'h0 : istat_reg) | istat_set;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      ctrl_reg <= pscr_pkg::CTRL_RESET;
      flags_reg <= 8'h00;
      ena_reg <= 8'h00;
      istat_reg <= 2'h0;
      imask_reg <= 2'h0;
      rdata_reg <= 16'h0000;
      // Following the link through reset keeps its release from looking like a change.
      link_prev_reg <= link_ok;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      flags_reg <= flags_next;
      istat_reg <= istat_next;
      link_prev_reg <= link_ok;
      if (wr && sel_events)
      begin
        ena_reg <= wdata[7:0];
      end
      if (wr && sel_imask)
      begin
        imask_reg <= wdata[1:0];
      end
      rdata_reg <= rd ? rd_mux : 16'h0000;
    end
  end

  // Straps are caught once after reset release, never under the reset itself.
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      strap_taken_reg <= 1'b0;
      strap_dup_reg <= 1'b0;
      strap_spd_reg <= 1'b1;
      duplex_reg <= 1'b0;
      speed_reg <= pscr_pkg::STATUS_RESET[pscr_pkg::STS_SPEED];
    end
    else
    begin
      if (!strap_taken_reg)
      begin
        strap_dup_reg <= strap_duplex;
        strap_spd_reg <= strap_speed10;
        strap_taken_reg <= 1'b1;
      end
      duplex_reg <= duplex_now;
      speed_reg <= speed_now;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      en_sync_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
    end
    else
    begin
      en_sync_reg <= {en_sync_reg[0], energy_det};
      pin_sync_reg <= {pin_sync_reg[0], pin_in};
    end
  end

  // Link pulse timer only runs while asleep, so it costs nothing in normal use.
  always_ff @(posedge clk)
  begin
    if (!nrst || !sleep_now)
    begin
      nlp_cnt_reg <= 32'h00000000;
      nlp_reg <= 1'b0;
    end
    else if (nlp_cnt_reg == 32'(NLP_PERIOD - 1))
    begin
      nlp_cnt_reg <= 32'h00000000;
      nlp_reg <= 1'b1;
    end
    else
    begin
      nlp_cnt_reg <= nlp_cnt_reg + 32'h00000001;
      nlp_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pin_out_reg <= 1'b1;
      pin_oe_reg <= 1'b0;
      pwrdn_reg <= 1'b0;
      clk_off_reg <= 1'b0;
      sleep_reg <= 1'b0;
      col_reg <= 1'b0;
      irq_reg <= 1'b0;
      fifo_depth_reg <= 4'h5;
    end
    else
    begin
      pin_oe_reg <= pin_is_irq;
      pin_out_reg <= assert_irq ^ ctrl_reg[pscr_pkg::CTRL_IRQ_POL];
      pwrdn_reg <= !pin_is_irq && !pin_sync_reg[1];
      clk_off_reg <= ctrl_reg[pscr_pkg::CTRL_CLK_OFF] && ieee_pwrdn;
      sleep_reg <= sleep_now;
      col_reg <= col_raw && (!duplex_reg || ctrl_reg[pscr_pkg::CTRL_COL_FD]);
      irq_reg <= |(istat_next & imask_reg);
      fifo_depth_reg <= depth_of(ctrl_reg[pscr_pkg::CTRL_FIFO_HI:pscr_pkg::CTRL_FIFO_LO]);
    end
  end

  assign rdata = rdata_reg;
  assign pin_out = pin_out_reg;
  assign pin_oe = pin_oe_reg;
  assign pwrdn_req = pwrdn_reg;
  assign clk_off = clk_off_reg;
  assign sleep_active = sleep_reg;
  assign nlp_pulse = nlp_reg;
  assign scr_bypass = ctrl_reg[pscr_pkg::CTRL_SCR_BYP];
  // Depth steers the external loopback FIFO that spans rx and tx clocks.
  assign fifo_depth = fifo_depth_reg;
  assign col_out = col_reg;
  assign irq = irq_reg;

  chk_clk_off_gate: assert property (@(posedge clk) disable iff (!nrst)
    clk_off |-> $past(ieee_pwrdn)) else $error("clock shut off outside power down");
  chk_irq_pin_level: assert property (@(posedge clk) disable iff (!nrst)
    $past(ctrl_reg[2]) && $past(ctrl_reg[3]) && $past(nrst) |-> !pin_out)
    else $error("test interrupt not shown active low");
  chk_test_irq: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_reg[2] && !ctrl_reg[3] ##1 nrst |-> pin_out) else $error("forced interrupt missing");
  chk_irq_gate: assert property (@(posedge clk) disable iff (!nrst)
    !ctrl_reg[1] && !ctrl_reg[2] && !ctrl_reg[3] ##1 nrst |-> !pin_out)
    else $error("interrupt without enable");
  chk_pin_role: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) |-> pin_oe == $past(ctrl_reg[0])) else $error("pin role wrong");
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_reg[7:5] == 3'h0) else $error("reserved bits not zero");
  chk_col_half: assert property (@(posedge clk) disable iff (!nrst)
    col_out |-> $past(col_raw)) else $error("collision without cause");
  chk_flag_keep: assert property (@(posedge clk) disable iff (!nrst)
    !(rd && sel_events) |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
    else $error("flag lost");
  chk_link_mirror: assert property (@(posedge clk) disable iff (!nrst)
    rd && sel_status |=> rdata[0] == $past(link_ok)) else $error("link bit wrong");
  chk_sleep_decode: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) |-> sleep_active == $past(sleep_now)) else $error("sleep decode wrong");

  // Each output is checked one cycle after the state that drives it, scr_bypass one cycle after the write that sets it.
  chk_clk_off_cause: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && $past(ctrl_reg[15]) && $past(ieee_pwrdn) |-> clk_off)
    else $error("clock not shut off in power down");
  chk_scr_follow: assert property (@(posedge clk) disable iff (!nrst)
    wr && sel_ctrl && !wake |=> scr_bypass == $past(wdata[11]))
    else $error("scrambler bypass not taken from write");
  chk_fifo_max: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && $past(ctrl_reg[9:8]) == 2'h3 |-> fifo_depth == 4'h8)
    else $error("loopback depth code 3 wrong");
  chk_fifo_min: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && $past(ctrl_reg[9:8]) == 2'h0 |-> fifo_depth == 4'h4)
    else $error("loopback depth code 0 wrong");
  chk_fifo_six: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && $past(ctrl_reg[9:8]) == 2'h2 |-> fifo_depth == 4'h6)
    else $error("loopback depth code 2 wrong");
  chk_col_half_dup: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && $past(col_raw) && !$past(duplex_reg) |-> col_out)
    else $error("collision lost in half duplex");
  chk_col_full_block: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && $past(duplex_reg) && !$past(ctrl_reg[4]) |-> !col_out)
    else $error("collision in full duplex while disabled");
  chk_sleep_gate: assert property (@(posedge clk) disable iff (!nrst)
    !ctrl_reg[14] |=> !sleep_active)
    else $error("sleep without power save enable");
  chk_reserved_mode: assert property (@(posedge clk) disable iff (!nrst)
    ctrl_reg[13:12] == 2'h1 |=> !sleep_active)
    else $error("reserved power save code acted");
  chk_nlp_sleep: assert property (@(posedge clk) disable iff (!nrst)
    nlp_pulse |-> $past(sleep_now))
    else $error("link pulse outside sleep");
  chk_nlp_single: assert property (@(posedge clk) disable iff (!nrst)
    nlp_pulse |=> !nlp_pulse)
    else $error("link pulse longer than one cycle");
  chk_wake_clear: assert property (@(posedge clk) disable iff (!nrst)
    wake |=> !ctrl_reg[14])
    else $error("energy did not end sleep");
  chk_duplex_fixed: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && !$past(an_enable) && $past(enhanced_mode) |-> duplex_reg)
    else $error("duplex not fixed full");
  chk_speed_fixed: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && !$past(an_enable) && $past(enhanced_mode) |-> speed_reg)
    else $error("speed not fixed 10");
  chk_duplex_strap: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && !$past(an_enable) && !$past(enhanced_mode) |-> duplex_reg == $past(strap_dup_reg))
    else $error("duplex not from strap");
  chk_speed_strap: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && !$past(an_enable) && !$past(enhanced_mode) |-> speed_reg == $past(strap_spd_reg))
    else $error("speed not from strap");
  chk_duplex_an: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && $past(an_enable) |-> duplex_reg == $past(an_duplex))
    else $error("duplex not negotiated value");
  chk_speed_an: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && $past(an_enable) |-> speed_reg == $past(an_speed10))
    else $error("speed not negotiated value");
  chk_events_clear: assert property (@(posedge clk) disable iff (!nrst)
    rd && sel_events && !(|flag_events) |=> flags_reg == 8'h00)
    else $error("event flags not cleared by read");
  chk_events_set: assert property (@(posedge clk) disable iff (!nrst)
    |flag_events |=> (flags_reg & $past(flag_events)) == $past(flag_events))
    else $error("event flag not set");
  chk_irq_event: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && $past(ctrl_reg[1]) && $past(pend) && !$past(ctrl_reg[3]) |-> pin_out)
    else $error("enabled event gave no interrupt");
  chk_pwrdn_pin: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && $past(ctrl_reg[0]) |-> !pwrdn_req)
    else $error("power down taken while pin is an output");
  chk_istat_set: assert property (@(posedge clk) disable iff (!nrst)
    |istat_set |=> (istat_reg & $past(istat_set)) == $past(istat_set))
    else $error("block status event lost");
  chk_blk_irq: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && $past(|(istat_reg & imask_reg)) && !$past(rd && sel_istat) |-> irq)
    else $error("block interrupt missing");
  chk_rdata_idle: assert property (@(posedge clk) disable iff (!nrst)
    !rd |=> rdata == 16'h0000)
    else $error("read data without read");
  chk_ctrl_write: assert property (@(posedge clk) disable iff (!nrst)
    wr && sel_ctrl && !wake |=> ctrl_reg == ($past(wdata) & pscr_pkg::CTRL_WR_MASK))
    else $error("control write not taken");

endmodule // pscr_regs
